// ===== logic/le_order_pkg.sv
// constants and types shared by the byte-order and restart logic
// assumes one core clock; all users import the whole package
package le_order_pkg;

   // ==========================================================
   // widths
   localparam int ADDR_W = 32;
   localparam int LANES  = 8;
   localparam int DATA_W = LANES * 8;

   // ==========================================================
   // address munge constants, xor on the low three address bits
   localparam logic [2:0] MUNGE_BYTE  = 3'h7;
   localparam logic [2:0] MUNGE_HALF  = 3'h6;
   localparam logic [2:0] MUNGE_WORD  = 3'h4;
   localparam logic [2:0] MUNGE_DWORD = 3'h0;
   // multi-register operands must be word aligned
   localparam logic [2:0] MULTI_ALIGN_MASK = 3'h3;

   // ==========================================================
   // values after reset
   localparam logic [ADDR_W-1:0] RST_ADDR  = 32'h0000_0000;
   localparam logic [DATA_W-1:0] RST_DATA  = 64'h0000_0000_0000_0000;
   localparam logic [LANES-1:0]  RST_LANES = 8'h00;

   // ==========================================================
   // operand size and access kind
   typedef enum logic [1:0] {
      SIZE_BYTE  = 2'b00,
      SIZE_HALF  = 2'b01,
      SIZE_WORD  = 2'b10,
      SIZE_DWORD = 2'b11
   } size_t;

   typedef enum logic [1:0] {
      KIND_SINGLE = 2'b00,
      KIND_MULTI  = 2'b01,
      KIND_STRING = 2'b10,
      KIND_FETCH  = 2'b11
   } kind_t;

   // low address bits that must be zero for natural alignment
   function automatic logic [2:0] align_mask(input size_t size);
      logic [2:0] m;
      m = 3'h0;
      unique case (size)
         SIZE_BYTE:  m = 3'h0;
         SIZE_HALF:  m = 3'h1;
         SIZE_WORD:  m = 3'h3;
         SIZE_DWORD: m = 3'h7;
      endcase
      return m;
   endfunction : align_mask

   // little-endian munge value for an operand size
   function automatic logic [2:0] munge_value(input size_t size);
      logic [2:0] m;
      m = MUNGE_DWORD;
      unique case (size)
         SIZE_BYTE:  m = MUNGE_BYTE;
         SIZE_HALF:  m = MUNGE_HALF;
         SIZE_WORD:  m = MUNGE_WORD;
         SIZE_DWORD: m = MUNGE_DWORD;
      endcase
      return m;
   endfunction : munge_value

   // lane i of a double word moves to lane 7 - i
   function automatic logic [DATA_W-1:0] reverse_lanes(input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] r;
      r = RST_DATA;
      for (int i = 0; i < LANES; i++) begin
         r[i*8 +: 8] = d[(LANES-1-i)*8 +: 8];
      end
      return r;
   endfunction : reverse_lanes

endpackage : le_order_pkg

// ===== logic/byte_lane_if.sv
// carrier between the main block and its lane reverser
// assumes a purely combinational reverser on the far side
interface byte_lane_if #(parameter int LANES = 8);
   logic                 reverse;
   logic [LANES*8-1:0]   in_data;
   logic [LANES*8-1:0]   out_data;

   modport user (output reverse, output in_data, input out_data);
   modport flip (input reverse, input in_data, output out_data);
endinterface : byte_lane_if

// ===== logic/lane_reverser.sv
// byte lane reverser for one double word
// assumes the caller registers the result
module lane_reverser #(
   parameter int LANES = 8
) (
   byte_lane_if.flip lanes
);
   // refuse widths that leave nothing to swap
   if (LANES < 2) begin : g_bad_lanes
      $error("lane_reverser needs at least two lanes");
   end

   // ==========================================================
   // lane swap
   genvar g;
   wire [LANES*8-1:0] swapped;
   for (g = 0; g < LANES; g++) begin : g_lane
      assign swapped[g*8 +: 8] = lanes.in_data[(LANES-1-g)*8 +: 8];
   end
   assign lanes.out_data = lanes.reverse ? swapped : lanes.in_data;
endmodule : lane_reverser

// ===== logic/le_io_byte_order_and_restart.sv
// load/store side byte ordering, address munging and restart classification
// assumes requester and memory share clk_in; boundary flags come from translation
module le_io_byte_order_and_restart
   import le_order_pkg::*;
(
   // clock and reset
   input  wire logic                         clk_in,
   input  wire logic                         rst_n_in,
   // mode
   input  wire logic                         le_mode_in,
   // request from the core
   input  wire logic                         req_valid_in,
   output logic                              req_ready_out,
   input  wire logic [le_order_pkg::ADDR_W-1:0] req_addr_in,
   input  le_order_pkg::size_t               req_size_in,
   input  le_order_pkg::kind_t               req_kind_in,
   input  wire logic                         req_io_in,
   input  wire logic                         req_write_in,
   input  wire logic [le_order_pkg::DATA_W-1:0] req_wdata_in,
   // boundary information from translation
   input  wire logic                         cross_page_in,
   input  wire logic                         cross_area_in,
   input  wire logic                         cross_segment_in,
   input  wire logic                         page_attr_differ_in,
   input  wire logic                         within_area_in,
   // memory side
   output logic                              mem_valid_out,
   input  wire logic                         mem_ready_in,
   output logic [le_order_pkg::ADDR_W-1:0]   mem_addr_out,
   output logic [le_order_pkg::LANES-1:0]    mem_lanes_out,
   output logic                              mem_write_out,
   output logic [le_order_pkg::DATA_W-1:0]   mem_wdata_out,
   input  wire logic                         mem_rvalid_in,
   input  wire logic [le_order_pkg::DATA_W-1:0] mem_rdata_in,
   // answers to the core
   output logic                              rd_valid_out,
   output logic [le_order_pkg::DATA_W-1:0]   rd_data_out,
   output logic                              align_fault_out,
   output logic                              restart_ok_out,
   output logic                              slow_path_out,
   output logic                              optimal_out
);
   import le_order_pkg::*;

   // ==========================================================
   // request decode
   wire        accept       = req_valid_in && req_ready_out;
   wire [2:0]  low_addr     = req_addr_in[2:0];
   wire        misaligned   = (low_addr & align_mask(req_size_in)) != 3'h0;
   wire        is_nonscalar = (req_kind_in == KIND_MULTI) || (req_kind_in == KIND_STRING);
   wire        le_nonscalar = le_mode_in && is_nonscalar;
   wire        multi_unalig = (req_kind_in == KIND_MULTI)
                              && ((low_addr & MULTI_ALIGN_MASK) != 3'h0);
   wire        fault        = le_nonscalar || multi_unalig;
   wire        any_cross    = cross_page_in || cross_area_in || cross_segment_in;
   wire        slow_cross   = cross_segment_in || cross_area_in
                              || (cross_page_in && page_attr_differ_in);
   wire        area_safe    = !le_mode_in && within_area_in;
   wire        single_rst   = misaligned && (any_cross || le_mode_in) && !area_safe;
   wire        restart_ok   = is_nonscalar ? any_cross : single_rst;
   wire        io_reverse   = le_mode_in && req_io_in;
   // fetches are word sized and munge like words
   wire size_t eff_size     = size_t'((req_kind_in == KIND_FETCH) ? SIZE_WORD : req_size_in);
   wire [2:0]  munge        = (le_mode_in && !req_io_in) ? munge_value(eff_size)
                                                         : MUNGE_DWORD;
   wire [ADDR_W-1:0] next_addr = {req_addr_in[ADDR_W-1:3], low_addr ^ munge};
   wire [3:0]  nbytes       = 4'(1) << eff_size;
   wire [15:0] lane_span    = (16'((16'h1 << nbytes) - 16'h1)) << next_addr[2:0];
   wire [LANES-1:0] next_lanes = lane_span[LANES-1:0];

   assign req_ready_out = !mem_valid_out || mem_ready_in;

   // ==========================================================
   // lane reversers for write and read data
   byte_lane_if #(.LANES(LANES)) wr_if ();
   byte_lane_if #(.LANES(LANES)) rd_if ();
   logic rd_reverse;

   assign wr_if.reverse = io_reverse;
   assign wr_if.in_data = req_wdata_in;
   assign rd_if.reverse = rd_reverse;
   assign rd_if.in_data = mem_rdata_in;

   lane_reverser #(.LANES(LANES)) u_wr_rev (.lanes(wr_if));
   lane_reverser #(.LANES(LANES)) u_rd_rev (.lanes(rd_if));

   // ==========================================================
   // memory request stage
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mem_valid_out <= 1'b0;
      end else if (accept) begin
         mem_valid_out <= !fault;
      end else if (mem_ready_in) begin
         mem_valid_out <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mem_addr_out   <= RST_ADDR;
         mem_lanes_out  <= RST_LANES;
         mem_write_out  <= 1'b0;
         mem_wdata_out  <= RST_DATA;
         restart_ok_out <= 1'b0;
         slow_path_out  <= 1'b0;
         optimal_out    <= 1'b0;
         rd_reverse     <= 1'b0;
      end else if (accept && !fault) begin
         mem_addr_out   <= next_addr;
         mem_lanes_out  <= next_lanes;
         mem_write_out  <= req_write_in;
         mem_wdata_out  <= wr_if.out_data;
         restart_ok_out <= restart_ok;
         slow_path_out  <= slow_cross;
         optimal_out    <= !misaligned && !is_nonscalar;
         rd_reverse     <= io_reverse;
      end
   end

   // one-cycle pulse for a refused nonscalar or misaligned multiple
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         align_fault_out <= 1'b0;
      end else begin
         align_fault_out <= accept && fault;
      end
   end

   // ==========================================================
   // read return
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_valid_out <= 1'b0;
         rd_data_out  <= RST_DATA;
      end else begin
         rd_valid_out <= mem_rvalid_in;
         if (mem_rvalid_in) rd_data_out <= rd_if.out_data;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   property p_be_addr;
      accept && !le_mode_in && !fault |=> mem_addr_out == $past(req_addr_in);
   endproperty
   a_be_addr: assert property (p_be_addr) else $error("big-endian address modified");

   property p_io_reverse;
      accept && le_mode_in && req_io_in && !fault
         |=> mem_wdata_out == reverse_lanes($past(req_wdata_in))
             && mem_addr_out == $past(req_addr_in);
   endproperty
   a_io_reverse: assert property (p_io_reverse) else $error("io lanes not reversed");

   property p_be_data;
      accept && !le_mode_in && !fault |=> mem_wdata_out == $past(req_wdata_in);
   endproperty
   a_be_data: assert property (p_be_data) else $error("big-endian data changed");

   property p_word_munge;
      accept && le_mode_in && !req_io_in && !fault && req_kind_in == KIND_FETCH
         |=> mem_addr_out[2:0] == ($past(req_addr_in[2:0]) ^ 3'h4);
   endproperty
   a_word_munge: assert property (p_word_munge) else $error("fetch not munged");

   property p_le_nonscalar;
      accept && le_mode_in && is_nonscalar |=> align_fault_out && !mem_valid_out;
   endproperty
   a_le_nonscalar: assert property (p_le_nonscalar) else $error("le nonscalar issued");

   property p_string_any;
      accept && !le_mode_in && req_kind_in == KIND_STRING |=> !align_fault_out;
   endproperty
   a_string_any: assert property (p_string_any) else $error("string refused");

   property p_aligned_single;
      accept && !fault && !is_nonscalar && !misaligned |=> !restart_ok_out && optimal_out;
   endproperty
   a_aligned_single: assert property (p_aligned_single) else $error("aligned restartable");

   property p_le_misaligned;
      accept && le_mode_in && !is_nonscalar && misaligned |=> restart_ok_out;
   endproperty
   a_le_misaligned: assert property (p_le_misaligned) else $error("le misaligned");

   property p_nonscalar_cross;
      accept && !fault && is_nonscalar |=> restart_ok_out == $past(any_cross);
   endproperty
   a_nonscalar_cross: assert property (p_nonscalar_cross) else $error("multi restart");

   property p_attr_page;
      accept && !fault && cross_page_in && page_attr_differ_in |=> slow_path_out;
   endproperty
   a_attr_page: assert property (p_attr_page) else $error("attr page not slow");

   property p_area_safe;
      accept && !fault && !le_mode_in && within_area_in && !is_nonscalar
         |=> !restart_ok_out;
   endproperty
   a_area_safe: assert property (p_area_safe) else $error("area access restartable");

   property p_hold;
      mem_valid_out && !mem_ready_in |=> mem_valid_out && $stable(mem_addr_out);
   endproperty
   a_hold: assert property (p_hold) else $error("request dropped under stall");

   c_io_le: cover property (accept && le_mode_in && req_io_in && req_size_in == SIZE_DWORD);
   c_fault: cover property (accept && le_nonscalar);
   c_restart: cover property (accept && !fault && restart_ok ##1 mem_valid_out);
   c_stall: cover property ((mem_valid_out && !mem_ready_in) [*2]);

endmodule : le_io_byte_order_and_restart

// ===== tb/mem_model.sv
// memory side stand-in: random stalls, read data one cycle after acceptance
// assumes the block's memory handshake and one shared clock
module mem_model
   import le_order_pkg::*;
(
   // clock, reset and stall control
   input  wire logic                          clk_in,
   input  wire logic                          rst_n_in,
   input  wire logic                          slow_in,
   // request from the block
   input  wire logic                          mem_valid_in,
   input  wire logic                          mem_write_in,
   input  wire logic [le_order_pkg::ADDR_W-1:0] mem_addr_in,
   output logic                               mem_ready_out,
   // read return
   output logic                               mem_rvalid_out,
   output logic [le_order_pkg::DATA_W-1:0]    mem_rdata_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import le_order_pkg::*;

   logic [15:0] lfsr;
   logic        take_rd;

   assign take_rd = mem_valid_in && mem_ready_out && !mem_write_in;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lfsr           <= 16'h0021;
         mem_ready_out  <= 1'b0;
         mem_rvalid_out <= 1'b0;
         mem_rdata_out  <= 64'h0;
      end else begin
         lfsr           <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
         mem_ready_out  <= !slow_in || lfsr[0];
         mem_rvalid_out <= take_rd;
         // data follows the address, so a repeated read returns the same bytes
         if (take_rd)
            mem_rdata_out <= {mem_addr_in, ~mem_addr_in};
         else
            mem_rdata_out <= ~mem_rdata_out;
      end
   end
endmodule : mem_model

// ===== tb/le_io_byte_order_and_restart_test.sv
// self-checking bench for the byte-order and restart block
// assumes the memory stand-in in mem_model.sv and the shared package
module le_io_byte_order_and_restart_test
   import le_order_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // =========
   // signals
   logic              clk_in = 1'b0;
   logic              rst_n_in = 1'b0;
   logic              le = 1'b0, valid = 1'b0, io = 1'b0, wr = 1'b0, slow = 1'b0;
   logic [ADDR_W-1:0] addr = 32'h0, maddr;
   logic [DATA_W-1:0] wdata = 64'h0, mwdata, rdata, rd_data;
   size_t             size = SIZE_BYTE;
   kind_t             kind = KIND_SINGLE;
   logic [4:0]        cr = 5'h0; // page, area, segment, attr differ, within area
   logic              ready, mvalid, mready, mwrite, rvalid, rd_valid, fault, rs_ok, slowp, opt;
   logic [LANES-1:0]  lanes;
   int                err_count = 0, checks = 0, cycles = 0;
   logic [31:0]       seed = 32'h0000_0021;

   le_io_byte_order_and_restart le_io_byte_order_and_restart_i (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .le_mode_in(le), .req_valid_in(valid),
      .req_ready_out(ready), .req_addr_in(addr), .req_size_in(size), .req_kind_in(kind),
      .req_io_in(io), .req_write_in(wr), .req_wdata_in(wdata), .cross_page_in(cr[4]),
      .cross_area_in(cr[3]), .cross_segment_in(cr[2]), .page_attr_differ_in(cr[1]),
      .within_area_in(cr[0]), .mem_valid_out(mvalid), .mem_ready_in(mready),
      .mem_addr_out(maddr), .mem_lanes_out(lanes), .mem_write_out(mwrite),
      .mem_wdata_out(mwdata), .mem_rvalid_in(rvalid), .mem_rdata_in(rdata),
      .rd_valid_out(rd_valid), .rd_data_out(rd_data), .align_fault_out(fault),
      .restart_ok_out(rs_ok), .slow_path_out(slowp), .optimal_out(opt));
   mem_model mem_model_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .slow_in(slow),
      .mem_valid_in(mvalid), .mem_write_in(mwrite), .mem_addr_in(maddr),
      .mem_ready_out(mready), .mem_rvalid_out(rvalid), .mem_rdata_out(rdata));

   initial begin
      forever #2 clk_in = ~clk_in;
   end

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 30000) begin
         err_count++;
         results();
      end
   end

   // =========
   // helpers
   task automatic results;
      if (err_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results

   task automatic cmp_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_bit

   task automatic cmp_vec(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_vec

   function automatic logic [63:0] rev(input logic [63:0] d);
      logic [63:0] r;
      for (int i = 0; i < 8; i++) r[i*8 +: 8] = d[(7-i)*8 +: 8];
      return r;
   endfunction : rev

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd

   // one request at a negedge; valid stays up unless a read must return first
   task automatic run_req;
      logic [2:0]  mun, msk;
      logic [31:0] ea;
      logic [63:0] d;
      logic [15:0] ln;
      logic        ns, mis, ef, rs;
      int          n, w;
      n = 1 << int'(size);
      msk = 3'(n - 1);
      mun = 3'h7 ^ msk;
      ea = (le && !io) ? {addr[31:3], addr[2:0] ^ mun} : addr;
      ln = ((16'h1 << n) - 16'h1) << ea[2:0];
      ns = (kind == KIND_MULTI) || (kind == KIND_STRING);
      mis = (addr[2:0] & msk) != 3'h0;
      ef = (le && ns) || (kind == KIND_MULTI && addr[1:0] != 2'h0);
      rs = ns ? |cr[4:2] : mis && (|cr[4:2] || le) && !(!le && cr[0]);
      valid = 1'b1;
      w = 0;
      while (ready !== 1'b1 && w < 50) begin
         @(negedge clk_in);
         w++;
      end
      @(negedge clk_in);
      if (!wr && !ef) valid = 1'b0;
      cmp_bit(fault, ef);
      cmp_bit(mvalid, !ef);
      if (!ef) begin
         cmp_vec(64'(maddr), 64'(ea));
         if (!ns) cmp_vec(64'(lanes), 64'(ln[7:0]));
         cmp_bit(mwrite, wr);
         if (wr) cmp_vec(mwdata, (le && io) ? rev(wdata) : wdata);
         cmp_bit(rs_ok, rs);
         cmp_bit(slowp, cr[2] | cr[3] | (cr[4] & cr[1]));
         cmp_bit(opt, !mis && !ns);
         if (!wr) begin
            w = 0;
            while (rd_valid !== 1'b1 && w < 20) begin
               @(negedge clk_in);
               w++;
            end
            d = {ea, ~ea};
            cmp_bit(rd_valid, 1'b1);
            cmp_vec(rd_data, (le && io) ? rev(d) : d);
         end
      end
   endtask : run_req

   task automatic corner(input logic l, input kind_t k, input size_t s, input logic i_o,
                         input logic w, input logic [31:0] a, input logic [4:0] c);
      le = l;
      kind = k;
      io = i_o;
      addr = a;
      cr = c;
      size = size_t'((k == KIND_FETCH) ? SIZE_WORD : s);
      wr = w && k != KIND_FETCH;
      wdata = {rnd(), rnd()};
      run_req();
   endtask : corner

   // =========
   // sequence
   initial begin
      repeat (16) @(negedge clk_in);
      cmp_bit(ready, 1'b1);
      cmp_bit(mvalid, 1'b0);
      rst_n_in = 1'b1;
      @(negedge clk_in);
      corner(0, KIND_SINGLE, SIZE_BYTE, 0, 1, 32'h0000_0105, 5'h00);
      corner(1, KIND_SINGLE, SIZE_WORD, 1, 1, 32'h0000_0203, 5'h00);
      corner(1, KIND_SINGLE, SIZE_DWORD, 1, 0, 32'h0000_0308, 5'h00);
      corner(1, KIND_FETCH, SIZE_WORD, 0, 0, 32'h0000_0400, 5'h00);
      corner(0, KIND_MULTI, SIZE_WORD, 0, 0, 32'h0000_0502, 5'h00);
      corner(0, KIND_MULTI, SIZE_WORD, 0, 1, 32'h0000_0ffc, 5'h10);
      corner(0, KIND_STRING, SIZE_BYTE, 0, 0, 32'h0000_0603, 5'h04);
      corner(1, KIND_MULTI, SIZE_WORD, 0, 0, 32'h0000_0700, 5'h00);
      corner(1, KIND_STRING, SIZE_BYTE, 0, 1, 32'h0000_0800, 5'h00);
      corner(0, KIND_SINGLE, SIZE_WORD, 0, 0, 32'h0000_0ffe, 5'h11);
      corner(1, KIND_SINGLE, SIZE_HALF, 0, 1, 32'h0000_0901, 5'h00);
      corner(0, KIND_SINGLE, SIZE_DWORD, 0, 0, 32'h0000_1000, 5'h10);
      corner(0, KIND_SINGLE, SIZE_HALF, 0, 0, 32'h0000_1fff, 5'h12);
      for (int i = 0; i < 400; i++) begin
         logic [31:0] r;
         r = rnd();
         slow = i >= 200;
         corner(r[0], kind_t'(r[2:1]), size_t'(r[4:3]), r[5], r[6], rnd(), r[11:7]);
      end
      results();
   end
endmodule : le_io_byte_order_and_restart_test
